// >>> hdl/srr_pkg.sv
// Purpose: Constants and carrier types for the scaled readings register block
// Assumes: 16-bit holding registers addressed by a 16-bit register address
// Notes:   Energy counters span two registers, high half first
package srr_pkg;
	localparam logic [15:0] ADDR_HEALTH      = 16'h9c40;
	localparam logic [15:0] ADDR_VOLT_AN     = 16'h9c41;
	localparam logic [15:0] ADDR_VOLT_BN     = 16'h9c42;
	localparam logic [15:0] ADDR_VOLT_CN     = 16'h9c43;
	localparam logic [15:0] ADDR_CUR_A       = 16'h9c44;
	localparam logic [15:0] ADDR_CUR_B       = 16'h9c45;
	localparam logic [15:0] ADDR_CUR_C       = 16'h9c46;
	localparam logic [15:0] ADDR_REAL_PWR    = 16'h9c47;
	localparam logic [15:0] ADDR_REACT_PWR   = 16'h9c48;
	localparam logic [15:0] ADDR_APPAR_PWR   = 16'h9c49;
	localparam logic [15:0] ADDR_PWR_FACTOR  = 16'h9c4a;
	localparam logic [15:0] ADDR_FREQ        = 16'h9c4b;
	localparam logic [15:0] ADDR_VOLT_AB     = 16'h9c4c;
	localparam logic [15:0] ADDR_VOLT_BC     = 16'h9c4d;
	localparam logic [15:0] ADDR_VOLT_CA     = 16'h9c4e;
	localparam logic [15:0] ADDR_CUR_XFMR_NUM  = 16'h9c4f;
	localparam logic [15:0] ADDR_CUR_XFMR_MULT = 16'h9c50;
	localparam logic [15:0] ADDR_CUR_XFMR_DEN  = 16'h9c51;
	localparam logic [15:0] ADDR_VT_NUM      = 16'h9c52;
	localparam logic [15:0] ADDR_VT_MULT     = 16'h9c53;
	localparam logic [15:0] ADDR_VT_DEN      = 16'h9c54;
	localparam logic [15:0] ADDR_E_REAL_DEL  = 16'h9c55;
	localparam logic [15:0] ADDR_E_REAL_REC  = 16'h9c57;
	localparam logic [15:0] ADDR_E_REACT_DEL = 16'h9c59;
	localparam logic [15:0] ADDR_E_REACT_REC = 16'h9c5b;
	localparam logic [15:0] ADDR_E_APPAR     = 16'h9c5d;
	localparam logic [15:0] ADDR_CUR_N       = 16'h9c5f;
	localparam logic [15:0] ADDR_RSVD_FIRST  = 16'h9c60;
	localparam logic [15:0] ADDR_RSVD_LAST   = 16'h9ca2;
	localparam logic [15:0] ADDR_ENERGY_CLR  = 16'h9ca3;

	// Code limits of the offset-coded readings
	localparam logic [11:0] CODE_ZERO        = 12'h7ff;
	localparam logic [11:0] CODE_MAX         = 12'hfff;
	localparam logic [11:0] CODE_MIN         = 12'h000;
	localparam logic [11:0] PF_CODE_MIN      = 12'h417;
	localparam logic [11:0] PF_CODE_MAX      = 12'hbe7;
	localparam logic [11:0] FREQ_CODE_MAX    = 12'haaa;

	// Transformer ratio limits
	localparam logic [15:0] RATIO_NUM_MIN    = 16'h0001;
	localparam logic [15:0] RATIO_NUM_MAX    = 16'h270f;
	localparam logic [15:0] MULT_1           = 16'h0001;
	localparam logic [15:0] MULT_10          = 16'h000a;
	localparam logic [15:0] MULT_100         = 16'h0064;
	localparam logic [15:0] CUR_XFMR_DEN_5   = 16'h0005;

	// Energy counter ceiling, 99999999
	localparam logic [31:0] ENERGY_MAX       = 32'h05f5_e0ff;
	localparam logic [15:0] PASSWORD_OPEN    = 16'h15b3;

	// Energy format scale of the digit before the implied point
	typedef enum logic [1:0] {
		SRR_SCALE_UNITS,
		SRR_SCALE_KILO,
		SRR_SCALE_MEGA
	} srr_scale_t;

	typedef struct packed {
		logic [11:0] volt_an;
		logic [11:0] volt_bn;
		logic [11:0] volt_cn;
		logic [11:0] cur_a;
		logic [11:0] cur_b;
		logic [11:0] cur_c;
		logic [11:0] cur_n;
		logic [11:0] real_pwr;
		logic [11:0] react_pwr;
		logic [11:0] appar_pwr;
		logic [11:0] pwr_factor;
		logic [11:0] freq;
		logic [11:0] volt_ab;
		logic [11:0] volt_bc;
		logic [11:0] volt_ca;
	} srr_readings_t;

	typedef struct packed {
		logic [15:0] cur_xfmr_num;
		logic [15:0] cur_xfmr_mult;
		logic [15:0] cur_xfmr_den;
		logic [15:0] vt_num;
		logic [15:0] vt_mult;
		logic [15:0] vt_den;
	} srr_ratios_t;

	typedef struct packed {
		logic [31:0] real_del;
		logic [31:0] real_rec;
		logic [31:0] react_del;
		logic [31:0] react_rec;
		logic [31:0] appar;
	} srr_energy_t;
endpackage

// >>> hdl/srr_block.sv
// Purpose: Holding register bank of scaled readings for a remote master
// Assumes: Engine inputs are on clk; one request per cycle on the port
// Notes:   Reads answer one cycle after the strobe; writes never stall
// Operation
// (R1) Every register is read-only except the energy-clear command register.
// (R2) Health flag reads 0 when operating properly, 1 otherwise, nothing else.
// (R3) Phase-neutral voltage codes span 2047 to 4095, 150 V full scale.
// (R4) Phase current codes span 0 to 4095, zero at 2047, 10 A scale.
// (R5) Neutral current uses the same coding as phase currents.
// (R6) Total powers coded 0..4095 around 2047, 3000 full scale.
// (R7) Power factor code spans 1047 to 3047; value is (code - 2047) / 1000.
// (R8) Frequency code saturates at 0 low and 2730 high.
// (R9) Line-line voltage codes span 2047 to 4095, 300 V full scale.
// (R10) Current ratio numerator 1..9999, multiplier 1/10/100, divisor 1 or 5.
// (R11) Voltage ratio numerator and denominator 1..9999, multiplier 1/10/100.
// (R12) Energy counters span two registers, high half first, max 99999999.
// (R13) Energy values have implied decimal point; scale set by energy format.
// (R14) Energy-clear register takes a password on write and reads as 0.
// (R15) Undefined and reserved addresses read zero; writes to them do nothing.
// (R16) Wrong password gives a normal answer but no clear; 5555 when disabled.
// (R17) Master reads both halves of a counter in one multi-register request; the port here takes one register per request.
`timescale 1ns/1ps
module srr_block (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   req_valid,
	input  wire logic                   req_write,
	input  wire logic [15:0]            req_addr,
	input  wire logic [15:0]            req_wdata,
	output logic                        rsp_valid,
	output logic [15:0]                 rsp_rdata,
	input  wire logic                   eng_fault,
	input  wire logic                   eng_data_ready,
	input  wire srr_pkg::srr_readings_t eng_readings,
	input  wire srr_pkg::srr_ratios_t   eng_ratios,
	input  wire srr_pkg::srr_energy_t   eng_energy,
	input  wire srr_pkg::srr_scale_t    eng_scale,
	input  wire logic                   pw_enabled,
	input  wire logic [15:0]            pw_value,
	output logic                        energy_clear,
	output srr_pkg::srr_scale_t         energy_scale,
	output logic                        health_flag
);

	srr_pkg::srr_readings_t rd;
	srr_pkg::srr_ratios_t   rt;
	srr_pkg::srr_energy_t   en;
	logic                   valid_data;
	logic [15:0]            next_rdata;
	logic                   pw_ok;

	function automatic logic [11:0] clamp12(input logic [11:0] v,
		input logic [11:0] lo, input logic [11:0] hi);
		logic [11:0] r;
		r = v;
		if (v < lo)
			r = lo;
		if (v > hi)
			r = hi;
		return r;
	endfunction

	function automatic logic [15:0] clamp16(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] r;
		r = v;
		if (v < lo)
			r = lo;
		if (v > hi)
			r = hi;
		return r;
	endfunction

	function automatic logic [15:0] fix_mult(input logic [15:0] v);
		logic [15:0] r;
		r = srr_pkg::MULT_1;
		if (v == srr_pkg::MULT_10 || v == srr_pkg::MULT_100)
			r = v;
		return r;
	endfunction

	function automatic logic [31:0] clamp_energy(input logic [31:0] v);
		logic [31:0] r;
		r = v;
		if (v > srr_pkg::ENERGY_MAX)
			r = srr_pkg::ENERGY_MAX;
		return r;
	endfunction

	// Snapshot of engine values, coerced into their legal code ranges
	always_ff @(posedge clk) begin
		if (rst) begin
			rd <= '0;
			valid_data <= 1'b0;
		end else if (eng_data_ready) begin
			valid_data <= 1'b1;
			rd.volt_an <= clamp12(eng_readings.volt_an, srr_pkg::CODE_ZERO,
				srr_pkg::CODE_MAX); // [R3]
			rd.volt_bn <= clamp12(eng_readings.volt_bn, srr_pkg::CODE_ZERO,
				srr_pkg::CODE_MAX); // [R3]
			rd.volt_cn <= clamp12(eng_readings.volt_cn, srr_pkg::CODE_ZERO,
				srr_pkg::CODE_MAX); // [R3]
			// Currents and powers use the full 12-bit span around zero
			rd.cur_a <= eng_readings.cur_a; // [R4]
			rd.cur_b <= eng_readings.cur_b; // [R4]
			rd.cur_c <= eng_readings.cur_c; // [R4]
			rd.cur_n <= eng_readings.cur_n; // [R5]
			rd.real_pwr <= eng_readings.real_pwr; // [R6]
			rd.react_pwr <= eng_readings.react_pwr; // [R6]
			rd.appar_pwr <= eng_readings.appar_pwr; // [R6]
			rd.pwr_factor <= clamp12(eng_readings.pwr_factor,
				srr_pkg::PF_CODE_MIN, srr_pkg::PF_CODE_MAX); // [R7]
			rd.freq <= clamp12(eng_readings.freq, srr_pkg::CODE_MIN,
				srr_pkg::FREQ_CODE_MAX); // [R8]
			rd.volt_ab <= clamp12(eng_readings.volt_ab, srr_pkg::CODE_ZERO,
				srr_pkg::CODE_MAX); // [R9]
			rd.volt_bc <= clamp12(eng_readings.volt_bc, srr_pkg::CODE_ZERO,
				srr_pkg::CODE_MAX); // [R9]
			rd.volt_ca <= clamp12(eng_readings.volt_ca, srr_pkg::CODE_ZERO,
				srr_pkg::CODE_MAX); // [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rt <= '0;
		end else if (eng_data_ready) begin
			rt.cur_xfmr_num <= clamp16(eng_ratios.cur_xfmr_num,
				srr_pkg::RATIO_NUM_MIN, srr_pkg::RATIO_NUM_MAX); // [R10]
			rt.cur_xfmr_mult <= fix_mult(eng_ratios.cur_xfmr_mult); // [R10]
			rt.cur_xfmr_den <=
				(eng_ratios.cur_xfmr_den == srr_pkg::CUR_XFMR_DEN_5) ?
				srr_pkg::CUR_XFMR_DEN_5 : srr_pkg::MULT_1; // [R10]
			rt.vt_num <= clamp16(eng_ratios.vt_num, srr_pkg::RATIO_NUM_MIN,
				srr_pkg::RATIO_NUM_MAX); // [R11]
			rt.vt_mult <= fix_mult(eng_ratios.vt_mult); // [R11]
			rt.vt_den <= clamp16(eng_ratios.vt_den, srr_pkg::RATIO_NUM_MIN,
				srr_pkg::RATIO_NUM_MAX); // [R11]
		end
	end

	// Energy snapshot; an update between the two half reads can mix two snapshots [R17]
	always_ff @(posedge clk) begin
		if (rst) begin
			en <= '0;
		end else if (eng_data_ready) begin
			en.real_del <= clamp_energy(eng_energy.real_del); // [R12]
			en.real_rec <= clamp_energy(eng_energy.real_rec); // [R12]
			en.react_del <= clamp_energy(eng_energy.react_del); // [R12]
			en.react_rec <= clamp_energy(eng_energy.react_rec); // [R12]
			en.appar <= clamp_energy(eng_energy.appar); // [R12]
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			energy_scale <= srr_pkg::SRR_SCALE_UNITS;
		else if (eng_data_ready && eng_scale != 2'h3)
			energy_scale <= eng_scale; // [R13]
	end

	always_ff @(posedge clk) begin
		if (rst)
			health_flag <= 1'b1;
		else
			health_flag <= eng_fault | ~valid_data; // [R2]
	end

	// Read mux; readings are zero until the first snapshot arrives
	always_comb begin
		next_rdata = 16'h0000;
		if (valid_data) begin
			unique case (req_addr)
				srr_pkg::ADDR_VOLT_AN:     next_rdata = {4'h0, rd.volt_an};
				srr_pkg::ADDR_VOLT_BN:     next_rdata = {4'h0, rd.volt_bn};
				srr_pkg::ADDR_VOLT_CN:     next_rdata = {4'h0, rd.volt_cn};
				srr_pkg::ADDR_CUR_A:       next_rdata = {4'h0, rd.cur_a};
				srr_pkg::ADDR_CUR_B:       next_rdata = {4'h0, rd.cur_b};
				srr_pkg::ADDR_CUR_C:       next_rdata = {4'h0, rd.cur_c};
				srr_pkg::ADDR_CUR_N:       next_rdata = {4'h0, rd.cur_n};
				srr_pkg::ADDR_REAL_PWR:    next_rdata = {4'h0, rd.real_pwr};
				srr_pkg::ADDR_REACT_PWR:   next_rdata = {4'h0, rd.react_pwr};
				srr_pkg::ADDR_APPAR_PWR:   next_rdata = {4'h0, rd.appar_pwr};
				srr_pkg::ADDR_PWR_FACTOR:  next_rdata = {4'h0, rd.pwr_factor};
				srr_pkg::ADDR_FREQ:        next_rdata = {4'h0, rd.freq};
				srr_pkg::ADDR_VOLT_AB:     next_rdata = {4'h0, rd.volt_ab};
				srr_pkg::ADDR_VOLT_BC:     next_rdata = {4'h0, rd.volt_bc};
				srr_pkg::ADDR_VOLT_CA:     next_rdata = {4'h0, rd.volt_ca};
				srr_pkg::ADDR_CUR_XFMR_NUM:  next_rdata = rt.cur_xfmr_num;
				srr_pkg::ADDR_CUR_XFMR_MULT: next_rdata = rt.cur_xfmr_mult;
				srr_pkg::ADDR_CUR_XFMR_DEN:  next_rdata = rt.cur_xfmr_den;
				srr_pkg::ADDR_VT_NUM:      next_rdata = rt.vt_num;
				srr_pkg::ADDR_VT_MULT:     next_rdata = rt.vt_mult;
				srr_pkg::ADDR_VT_DEN:      next_rdata = rt.vt_den;
				// High half at the lower address [R12]
				srr_pkg::ADDR_E_REAL_DEL:  next_rdata = en.real_del[31:16];
				16'h9c56:                  next_rdata = en.real_del[15:0];
				srr_pkg::ADDR_E_REAL_REC:  next_rdata = en.real_rec[31:16];
				16'h9c58:                  next_rdata = en.real_rec[15:0];
				srr_pkg::ADDR_E_REACT_DEL: next_rdata = en.react_del[31:16];
				16'h9c5a:                  next_rdata = en.react_del[15:0];
				srr_pkg::ADDR_E_REACT_REC: next_rdata = en.react_rec[31:16];
				16'h9c5c:                  next_rdata = en.react_rec[15:0];
				srr_pkg::ADDR_E_APPAR:     next_rdata = en.appar[31:16];
				16'h9c5e:                  next_rdata = en.appar[15:0];
				default:                   next_rdata = 16'h0000; // [R15] [R14]
			endcase
		end
		if (req_addr == srr_pkg::ADDR_HEALTH)
			next_rdata = {15'h0000, health_flag}; // [R2]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			rsp_valid <= req_valid; // [R16]
			// Writes are answered with zero data and change nothing but the clear pulse
			rsp_rdata <= (req_valid && !req_write) ? next_rdata :
				16'h0000; // [R1] [R15]
		end
	end

	assign pw_ok = pw_enabled ? (req_wdata == pw_value) :
		(req_wdata == srr_pkg::PASSWORD_OPEN);

	// Clear pulse only for a correct password at the command address
	always_ff @(posedge clk) begin
		if (rst)
			energy_clear <= 1'b0;
		else
			energy_clear <= req_valid && req_write &&
				req_addr == srr_pkg::ADDR_ENERGY_CLR && pw_ok; // [R1] [R14] [R16]
	end

endmodule

// >>> verif/srr_block_monitor.sv
// Purpose: Port-level assertions for the scaled readings register block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto the block from the testbench top file
`timescale 1ns/1ps
module srr_block_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_rdata,
	input wire logic        eng_fault,
	input wire logic        pw_enabled,
	input wire logic [15:0] pw_value,
	input wire logic        energy_clear,
	input wire logic        health_flag
);
	logic rd;
	logic good_pw;
	logic unmapped;
	assign rd = req_valid && !req_write;
	assign good_pw = req_valid && req_write
		&& req_addr == srr_pkg::ADDR_ENERGY_CLR
		&& req_wdata == (pw_enabled ? pw_value : srr_pkg::PASSWORD_OPEN);
	assign unmapped = req_addr < srr_pkg::ADDR_HEALTH
		|| req_addr > srr_pkg::ADDR_ENERGY_CLR
		|| req_addr inside {[srr_pkg::ADDR_RSVD_FIRST:srr_pkg::ADDR_RSVD_LAST]};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	answer_next_a: assert property (req_valid |=> rsp_valid)
		else $error("request not answered in the next cycle");
	write_zero_a: assert property (req_valid && req_write |=>
		rsp_valid && rsp_rdata == 16'h0000)
		else $error("write answered with nonzero data");
	clear_reads_a: assert property (rd &&
		req_addr == srr_pkg::ADDR_ENERGY_CLR |=> rsp_rdata == 16'h0000)
		else $error("clear command register read nonzero");
	unmapped_zero_a: assert property (rd && unmapped |=>
		rsp_rdata == 16'h0000)
		else $error("unmapped address read nonzero");
	clear_fires_a: assert property (good_pw |=> energy_clear)
		else $error("good password did not clear");
	clear_cause_a: assert property (energy_clear |-> $past(good_pw))
		else $error("clear pulse without a good password write");
	health_bits_a: assert property (rd &&
		req_addr == srr_pkg::ADDR_HEALTH |=> rsp_rdata[15:1] == 15'h0000)
		else $error("health register not 0 or 1");
	health_fault_a: assert property (eng_fault |=> health_flag)
		else $error("fault not shown in health flag");
	freq_sat_a: assert property (rd &&
		req_addr == srr_pkg::ADDR_FREQ |=> rsp_rdata <= 16'h0aaa)
		else $error("frequency code above saturation");
endmodule

// >>> verif/srr_master_model.sv
// Purpose: Remote master that polls the holding registers
// Assumes: Requests launched at the falling edge, one per cycle
// Notes:   Keeps the expected answer of each request in exp_q
`timescale 1ns/1ps
module srr_master_model (
	input  wire logic        clk,
	output logic             req_valid,
	output logic             req_write,
	output logic [15:0]      req_addr,
	output logic [15:0]      req_wdata
);
	logic [16:0] exp_q[$];
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr  = 16'h0000;
		req_wdata = 16'h0000;
	end
	// Counter halves go out back to back, high half first
	task automatic rq(input logic w, input logic [15:0] a, d,
		input logic [16:0] ex);
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr  = a;
		req_wdata = d;
		exp_q.push_back(ex);
	endtask
	// Released lines show the inverse of their last value
	task automatic idle();
		@(negedge clk);
		req_valid = 1'b0;
		req_write = ~req_write;
		req_addr  = ~req_addr;
		req_wdata = ~req_wdata;
	endtask
endmodule

// >>> verif/srr_block_tb.sv
// Purpose: Self-checking testbench for the scaled readings register block
// Assumes: Master model drives requests at the falling edge
// Notes:   Engine codes are random from a fixed seed
`timescale 1ns/1ps
module srr_block_tb;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   req_valid, req_write, rsp_valid;
	logic [15:0]            req_addr, req_wdata, rsp_rdata, pw_value, pw;
	logic                   eng_fault, eng_data_ready, pw_enabled;
	logic                   energy_clear, health_flag;
	srr_pkg::srr_readings_t eng_readings;
	srr_pkg::srr_ratios_t   eng_ratios;
	srr_pkg::srr_energy_t   eng_energy;
	srr_pkg::srr_scale_t    eng_scale, energy_scale;
	logic [11:0]            c[15];
	logic [15:0]            r[6];
	logic [31:0]            e[5];
	logic [15:0]            ex[32];
	logic [11:0] lo[15] = '{12'h7ff, 12'h7ff, 12'h7ff, 12'h0, 12'h0, 12'h0,
		12'h0, 12'h0, 12'h0, 12'h0, 12'h417, 12'h0, 12'h7ff, 12'h7ff, 12'h7ff};
	logic [15:0]            mul[3] = '{16'h0001, 16'h000a, 16'h0064};
	int                     seed = 98;
	int                     error_cnt = 0;
	int                     total_checks = 0;
	always #2 clk = ~clk;
	srr_block srr_block_i (.clk(clk), .rst(rst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .eng_fault(eng_fault),
		.eng_data_ready(eng_data_ready), .eng_readings(eng_readings),
		.eng_ratios(eng_ratios), .eng_energy(eng_energy),
		.eng_scale(eng_scale), .pw_enabled(pw_enabled), .pw_value(pw_value),
		.energy_clear(energy_clear), .energy_scale(energy_scale),
		.health_flag(health_flag));
	srr_master_model srr_master_model_i (.clk(clk), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata));
	task automatic chk(input logic [16:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		// An expected answer that never arrived counts as a mismatch
		if (srr_master_model_i.exp_q.size() != 0)
			error_cnt++;
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(negedge clk) begin
		if (rsp_valid === 1'b1)
			chk({energy_clear, rsp_rdata},
				srr_master_model_i.exp_q.pop_front());
	end
	task automatic rd(input logic [15:0] a, v);
		srr_master_model_i.rq(1'b0, a, 16'h0000, {1'b0, v});
	endtask
	task automatic wr(input logic [15:0] a, d, input logic clr);
		srr_master_model_i.rq(1'b1, a, d, {clr, 16'h0000});
	endtask
	task automatic read_all();
		for (int a = 0; a < 32; a++)
			rd(16'h9c40 + 16'(a), ex[a]);
		srr_master_model_i.idle();
	endtask
	task automatic map();
		for (int i = 0; i < 15; i++)
			ex[i == 6 ? 31 : (i < 6 ? i + 1 : i)] = {4'h0, c[i]};
		for (int j = 0; j < 6; j++)
			ex[15 + j] = r[j];
		for (int k = 0; k < 5; k++)
			{ex[21 + 2 * k], ex[22 + 2 * k]} = e[k];
	endtask
	task automatic apply();
		@(negedge clk);
		eng_readings = {>>{c}};
		eng_ratios = {>>{r}};
		eng_energy = {>>{e}};
		eng_data_ready = 1'b1;
		@(negedge clk);
		eng_data_ready = 1'b0;
		// Health flag settles one cycle after the snapshot is taken
		@(negedge clk);
	endtask
	initial begin
		#20000;
		error_cnt++;
		test_done();
	end
	initial begin
		{eng_fault, eng_data_ready, pw_value} = '0;
		{eng_readings, eng_ratios, eng_energy} = '0;
		eng_scale = srr_pkg::SRR_SCALE_UNITS;
		pw_enabled = 1'b1;
		foreach (ex[i]) ex[i] = 16'h0000;
		ex[0] = 16'h0001;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk(17'(health_flag), 17'h00001);
		read_all();
		for (int i = 0; i < 15; i++)
			c[i] = 12'(lo[i] + $unsigned($random(seed))
				% ((i == 10 ? 32'hbe7 : i == 11 ? 32'haaa : 32'hfff) - lo[i] + 1));
		foreach (r[j]) r[j] = 16'h0001 + 16'($unsigned($random(seed)) % 32'h270f);
		r[1] = mul[$unsigned($random(seed)) % 3];
		r[4] = mul[$unsigned($random(seed)) % 3];
		r[2] = ($random(seed) & 1) ? 16'h0005 : 16'h0001;
		foreach (e[k]) e[k] = $unsigned($random(seed)) % 32'h05f5_e100;
		map();
		ex[0] = 16'h0000;
		apply();
		read_all();
		wr(16'h9c41, 16'hffff, 1'b0);
		wr(16'h9c60, 16'h1234, 1'b0);
		wr(16'h1234, 16'h0001, 1'b0);
		rd(16'h9ca2, 16'h0000);
		rd(16'hffff, 16'h0000);
		read_all();
		c[0] = 12'h005;
		c[10] = 12'hfff;
		c[11] = 12'hfff;
		r[1] = 16'h0007;
		r[2] = 16'h0003;
		r[5] = 16'h0000;
		e[0] = 32'hffff_ffff;
		map();
		{ex[1], ex[10], ex[11], ex[16], ex[17], ex[20]} =
			{16'h07ff, 16'h0be7, 16'h0aaa, 16'h0001, 16'h0001, 16'h0001};
		{ex[21], ex[22]} = 32'h05f5_e0ff;
		apply();
		read_all();
		pw = 16'($random(seed));
		pw_value = pw;
		wr(16'h9ca3, ~pw, 1'b0);
		wr(16'h9ca3, pw, 1'b1);
		rd(16'h9ca3, 16'h0000);
		srr_master_model_i.idle();
		pw_enabled = 1'b0;
		wr(16'h9ca3, 16'h15b3, 1'b1);
		wr(16'h9ca3, 16'hea4c, 1'b0);
		srr_master_model_i.idle();
		// Code 3 is not a scale and must leave the mega setting in place
		for (int s = 0; s < 4; s++) begin
			eng_scale = srr_pkg::srr_scale_t'(s);
			apply();
			@(negedge clk);
			chk(17'(energy_scale), 17'(s == 3 ? 2 : s));
		end
		eng_fault = 1'b1;
		repeat (2) @(negedge clk);
		chk(17'(health_flag), 17'h00001);
		rd(srr_pkg::ADDR_HEALTH, 16'h0001);
		srr_master_model_i.idle();
		repeat (3) @(negedge clk);
		test_done();
	end
endmodule
bind srr_block srr_block_monitor srr_block_monitor_i (.clk(clk), .rst(rst),
	.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
	.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
	.eng_fault(eng_fault), .pw_enabled(pw_enabled), .pw_value(pw_value),
	.energy_clear(energy_clear), .health_flag(health_flag));
